// File: design/udc_arb.sv
// fixed two-level priority picker
`timescale 1ns/1ps
module udc_arb
  import udc_pkg::*;
(
  udc_arb_if.arb bus
);
  logic [5:0] hi;
  logic [5:0] lo;

  // lowest set bit wins; msb flags a hit
  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) r = {1'b1, 5'(i)};
    end
    return r;
  endfunction : first_set

  always_comb begin
    hi = first_set(bus.req & bus.prio);
    lo = first_set(bus.req);
    bus.gnt_valid = hi[5] | lo[5];
    bus.gnt_idx   = hi[5] ? hi[4:0] : lo[4:0];
  end
endmodule : udc_arb

// File: design/udc_arb_if.sv
// request and grant bundle between engine and priority arbiter
`timescale 1ns/1ps
interface udc_arb_if;
  logic [31:0] req;
  logic [31:0] prio;
  logic        gnt_valid;
  logic [4:0]  gnt_idx;
  modport arb (input req, input prio, output gnt_valid, output gnt_idx);
  modport ctl (output req, output prio, input gnt_valid, input gnt_idx);
endinterface : udc_arb_if

// File: design/udc_cfg.svh
// constants for the dma channel arbiter and control engine
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH
`define UDC_NCH         32
`define UDC_REG_ENA_SET 8'h00
`define UDC_REG_ENA_CLR 8'h04
`define UDC_REG_PRI_SET 8'h08
`define UDC_REG_PRI_CLR 8'h0C
`define UDC_REG_BO_SET  8'h10
`define UDC_REG_BO_CLR  8'h14
`define UDC_REG_BASE    8'h18
`define UDC_REG_ALT     8'h1C
`define UDC_REG_STAT    8'h20
`define UDC_RST_WORD    32'h0000_0000
`define UDC_BASE_MASK   32'hFFFF_FC00
`define UDC_ALT_SH      9
`define UDC_STRUCT_SH   4
`define UDC_OFS_SRC     32'h0000_0000
`define UDC_OFS_DST     32'h0000_0004
`define UDC_OFS_CW      32'h0000_0008
`define UDC_CW_DINC     31:30
`define UDC_CW_DSZ      29:28
`define UDC_CW_SINC     27:26
`define UDC_CW_SSZ      25:24
`define UDC_CW_ARB      23:14
`define UDC_CW_KEEP     31:14
`define UDC_CW_CNT      13:3
`define UDC_CW_BURST    2
`define UDC_CW_MODE     1:0
`define UDC_MODE_STOP   2'h0
`define UDC_MODE_BASIC  2'h1
`define UDC_MODE_AUTO   2'h2
`define UDC_MODE_PP     2'h3
`define UDC_INC_NONE    2'h3
`define UDC_SZ_WORD     2'h2
`define UDC_RESP_OKAY   2'h0
`define UDC_RESP_SLVERR 2'h2
`endif

// File: design/udc_pkg.sv
// types shared by the dma channel engine
package udc_pkg;
  typedef logic [4:0]  udc_chan_t;
  typedef logic [10:0] udc_cnt_t;
  typedef enum logic [2:0] {ST_IDLE, ST_CW, ST_SP, ST_DP, ST_RD, ST_WR, ST_WB} udc_state_e;
endpackage : udc_pkg

// File: design/udc_sync.sv
// two-flop synchroniser for request pins
`timescale 1ns/1ps
module udc_sync #(
  parameter int W = 64
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : udc_sync

// File: design/udc_top.sv
// dma channel engine: arbitration, control table walk, register slave
//
// Behaviour
// - equal level: lowest channel number wins, channel 0 ranks highest
// - a set priority bit outranks every default-priority channel
// - high-priority channels are ordered by channel number among themselves
// - priority bit set and cleared through separate set and clear registers
// - serve winner for its arbitration count, then re-arbitrate
// - arbitration count per channel, any value 1 to 1024
// - memory master yields to processor, even mid-burst, then resumes
// - single plus burst request on a burst channel counts as burst
// - single request alone moves one item outside auto mode, then re-arbitrates
// - burst moves min of arbitration count and remaining items
// - burst-only bit set makes the channel ignore single requests
// - primary at base plus 16 per channel, alternates from 0x200
// - structure: source end 0x0, destination end 0x4, control 0x8
// - end pointers are inclusive; fixed side uses pointer directly
// - write back count and mode, ending at 0 and Stop; pointers untouched
// - software enables and disables; engine disables at transfer end except in ping-pong mode
// - Stop mode: no transfer, channel enable cleared
// - control word holds sizes, increments, arb count, count, burst, mode
// - item sizes 8/16/32, increments byte/half/word/none per side
// - basic mode moves only while items remain and request stays
// - auto mode finishes the whole transfer once any request is seen
// - ping-pong: completion pulse, then continue on the other structure
`timescale 1ns/1ps
`include "udc_cfg.svh"
module udc_top
  import udc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic [31:0] dma_sreq,
  input  wire logic [31:0] dma_breq,
  input  wire logic        cpu_bus_busy,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [1:0]       mem_size,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic [31:0]      chan_done,
  output logic             dma_busy
);
  // ==========================================================
  // functions
  function automatic logic [31:0] tbl_addr(input logic [31:0] base, input logic a,
                                           input udc_chan_t c, input logic [31:0] ofs);
    return (base & `UDC_BASE_MASK) + (32'(a) << `UDC_ALT_SH)
           + (32'(c) << `UDC_STRUCT_SH) + ofs;
  endfunction : tbl_addr

  function automatic logic [31:0] item_addr(input logic [31:0] ep, input udc_cnt_t r,
                                            input logic [1:0] inc);
    if (inc == `UDC_INC_NONE) return ep;
    return ep - (32'(r - 11'd1) << inc);
  endfunction : item_addr

  function automatic logic [31:0] cw_wb(input logic [31:0] w, input udc_cnt_t r);
    return {w[`UDC_CW_KEEP], r, w[`UDC_CW_BURST],
            (r == 11'd0) ? `UDC_MODE_STOP : w[`UDC_CW_MODE]};
  endfunction : cw_wb

  function automatic logic mapped(input logic [7:0] a);
    return a inside {`UDC_REG_ENA_SET, `UDC_REG_ENA_CLR, `UDC_REG_PRI_SET,
                     `UDC_REG_PRI_CLR, `UDC_REG_BO_SET, `UDC_REG_BO_CLR,
                     `UDC_REG_BASE, `UDC_REG_ALT, `UDC_REG_STAT};
  endfunction : mapped

  // ==========================================================
  // declarations
  logic [63:0] req_sync;
  logic [31:0] sreq_s;
  logic [31:0] breq_s;
  logic [31:0] en;
  logic [31:0] prio;
  logic [31:0] bonly;
  logic [31:0] auto_run;
  logic [31:0] alt_sel;
  logic [31:0] tbl_base;
  udc_state_e  state;
  udc_chan_t   ch;
  logic        alt;
  logic        is_burst;
  logic [31:0] cw;
  udc_cnt_t    rem;
  udc_cnt_t    left;
  logic [31:0] src_end;
  logic [31:0] dst_end;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_q;
  logic [31:0] wm;
  logic [31:0] wd_q;
  logic [31:0] wdat;
  logic [3:0]  ws_q;
  logic [3:0]  wsel;
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic        ar_take;
  logic [31:0] ena_s;
  logic [31:0] ena_c;
  logic [31:0] pri_s;
  logic [31:0] pri_c;
  logic [31:0] bo_s;
  logic [31:0] bo_c;
  logic        base_we;
  logic        mem_done;
  logic [31:0] ch_mask;
  logic [1:0]  rd_mode;
  udc_cnt_t    rd_cnt;
  udc_cnt_t    rd_arbn;
  udc_cnt_t    rd_len;
  logic        stop_hit;
  logic        bo_hit;
  logic        auto_hit;
  logic        xfer_end;
  logic        cont;
  logic [31:0] eligible;

  // ==========================================================
  // request pins and arbitration
  udc_sync #(.W(64)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({dma_breq, dma_sreq}),
    .q     (req_sync)
  );
  assign sreq_s = req_sync[31:0];
  assign breq_s = req_sync[63:32];

  assign eligible = en & (breq_s | (sreq_s & ~bonly) | auto_run);

  udc_arb_if arb_bus ();
  assign arb_bus.req  = eligible;
  assign arb_bus.prio = prio;
  udc_arb u_arb (.bus(arb_bus.arb));

  // ==========================================================
  // transfer decode
  assign mem_done = mem_req & mem_ack;
  assign ch_mask  = 32'h0000_0001 << ch;
  assign rd_mode  = mem_rdata[`UDC_CW_MODE];
  assign rd_cnt   = mem_rdata[`UDC_CW_CNT];
  assign rd_arbn  = {1'b0, mem_rdata[`UDC_CW_ARB]} + 11'd1;
  assign rd_len   = (is_burst || rd_mode == `UDC_MODE_AUTO)
                    ? ((rd_arbn < rd_cnt) ? rd_arbn : rd_cnt) : 11'd1;
  assign stop_hit = (state == ST_CW) && mem_done && rd_mode == `UDC_MODE_STOP;
  assign bo_hit   = (state == ST_CW) && mem_done && rd_mode != `UDC_MODE_STOP
                    && mem_rdata[`UDC_CW_BURST] && !is_burst;
  assign auto_hit = (state == ST_CW) && mem_done && rd_mode == `UDC_MODE_AUTO;
  assign xfer_end = (state == ST_WB) && mem_done && rem == 11'd0;
  // basic mode drops out as soon as the peripheral withdraws
  assign cont = left > 11'd1 && rem > 11'd1 && en[ch]
                && (cw[`UDC_CW_MODE] != `UDC_MODE_BASIC || breq_s[ch] || sreq_s[ch]);

  // ==========================================================
  // sequencer and memory payload
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      ch        <= '0;
      alt       <= 1'b0;
      is_burst  <= 1'b0;
      cw        <= `UDC_RST_WORD;
      rem       <= '0;
      left      <= '0;
      src_end   <= `UDC_RST_WORD;
      dst_end   <= `UDC_RST_WORD;
      mem_we    <= 1'b0;
      mem_addr  <= `UDC_RST_WORD;
      mem_size  <= `UDC_SZ_WORD;
      mem_wdata <= `UDC_RST_WORD;
    end else begin
      case (state)
        ST_IDLE: begin
          if (arb_bus.gnt_valid) begin
            ch       <= arb_bus.gnt_idx;
            alt      <= alt_sel[arb_bus.gnt_idx];
            is_burst <= breq_s[arb_bus.gnt_idx] | auto_run[arb_bus.gnt_idx];
            mem_we   <= 1'b0;
            mem_size <= `UDC_SZ_WORD;
            mem_addr <= tbl_addr(tbl_base, alt_sel[arb_bus.gnt_idx],
                                 arb_bus.gnt_idx, `UDC_OFS_CW);
            state    <= ST_CW;
          end
        end
        ST_CW: begin
          if (mem_done) begin
            cw   <= mem_rdata;
            rem  <= rd_cnt;
            left <= rd_len;
            if (rd_mode == `UDC_MODE_STOP || bo_hit) begin
              state <= ST_IDLE;
            end else if (rd_cnt == 11'd0) begin
              mem_we    <= 1'b1;
              mem_wdata <= cw_wb(mem_rdata, 11'd0);
              state     <= ST_WB;
            end else begin
              mem_addr <= tbl_addr(tbl_base, alt, ch, `UDC_OFS_SRC);
              state    <= ST_SP;
            end
          end
        end
        ST_SP: begin
          if (mem_done) begin
            src_end  <= mem_rdata;
            mem_addr <= tbl_addr(tbl_base, alt, ch, `UDC_OFS_DST);
            state    <= ST_DP;
          end
        end
        ST_DP: begin
          if (mem_done) begin
            dst_end  <= mem_rdata;
            mem_addr <= item_addr(src_end, rem, cw[`UDC_CW_SINC]);
            mem_size <= cw[`UDC_CW_SSZ];
            state    <= ST_RD;
          end
        end
        ST_RD: begin
          if (mem_done) begin
            mem_we    <= 1'b1;
            mem_wdata <= mem_rdata;
            mem_addr  <= item_addr(dst_end, rem, cw[`UDC_CW_DINC]);
            mem_size  <= cw[`UDC_CW_DSZ];
            state     <= ST_WR;
          end
        end
        ST_WR: begin
          if (mem_done) begin
            rem  <= rem - 11'd1;
            left <= left - 11'd1;
            if (cont) begin
              mem_we   <= 1'b0;
              mem_addr <= item_addr(src_end, rem - 11'd1, cw[`UDC_CW_SINC]);
              mem_size <= cw[`UDC_CW_SSZ];
              state    <= ST_RD;
            end else begin
              mem_addr  <= tbl_addr(tbl_base, alt, ch, `UDC_OFS_CW);
              mem_size  <= `UDC_SZ_WORD;
              mem_wdata <= cw_wb(cw, rem - 11'd1);
              state     <= ST_WB;
            end
          end
        end
        ST_WB: begin
          if (mem_done) begin
            mem_we <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // memory request, withdrawn while the processor owns the bus
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_req <= 1'b0;
    end else if (cpu_bus_busy || mem_done) begin
      mem_req <= 1'b0;
    end else begin
      mem_req <= state != ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) dma_busy <= 1'b0;
    else dma_busy <= state != ST_IDLE;
  end

  // ==========================================================
  // channel flags; software set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en        <= `UDC_RST_WORD;
      prio      <= `UDC_RST_WORD;
      bonly     <= `UDC_RST_WORD;
      auto_run  <= `UDC_RST_WORD;
      alt_sel   <= `UDC_RST_WORD;
      tbl_base  <= `UDC_RST_WORD;
      chan_done <= `UDC_RST_WORD;
    end else begin
      en <= (en & ~ena_c & ~((stop_hit || (xfer_end && cw[`UDC_CW_MODE] != `UDC_MODE_PP))
             ? ch_mask : '0)) | ena_s;
      prio  <= (prio & ~pri_c) | pri_s;
      bonly <= (bonly & ~bo_c) | bo_s | (bo_hit ? ch_mask : '0);
      auto_run <= (auto_run & ~ena_c & ~((stop_hit || xfer_end) ? ch_mask : '0))
                  | (auto_hit ? ch_mask : '0);
      alt_sel <= alt_sel ^ ((xfer_end && cw[`UDC_CW_MODE] == `UDC_MODE_PP)
                 ? ch_mask : '0);
      chan_done <= xfer_end ? ch_mask : '0;
      if (base_we) tbl_base <= (tbl_base & ~wm) | (wdat & wm & `UDC_BASE_MASK);
    end
  end

  // ==========================================================
  // register write decode
  always_comb begin
    ena_s   = '0;
    ena_c   = '0;
    pri_s   = '0;
    pri_c   = '0;
    bo_s    = '0;
    bo_c    = '0;
    base_we = 1'b0;
    if (wr_fire) begin
      case (aw_q)
        `UDC_REG_ENA_SET: ena_s = wdat & wm;
        `UDC_REG_ENA_CLR: ena_c = wdat & wm;
        `UDC_REG_PRI_SET: pri_s = wdat & wm;
        `UDC_REG_PRI_CLR: pri_c = wdat & wm;
        `UDC_REG_BO_SET:  bo_s  = wdat & wm;
        `UDC_REG_BO_CLR:  bo_c  = wdat & wm;
        `UDC_REG_BASE:    base_we = 1'b1;
        default:          base_we = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // axi4-lite slave: write data captured when taken, applied once both halves meet
  assign aw_take = s_awvalid & s_awready;
  assign w_take  = s_wvalid & s_wready;
  assign wr_fire = aw_hold & (w_hold | w_take) & ~s_bvalid;
  assign ar_take = s_arvalid & s_arready;
  assign wdat = w_hold ? wd_q : s_wdata;
  assign wsel = w_hold ? ws_q : s_wstrb;
  assign wm = {{8{wsel[3]}}, {8{wsel[2]}}, {8{wsel[1]}}, {8{wsel[0]}}};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold   <= 1'b0;
      w_hold    <= 1'b0;
      aw_q      <= 8'h00;
      wd_q      <= `UDC_RST_WORD;
      ws_q      <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `UDC_RESP_OKAY;
    end else begin
      if (s_bvalid && s_bready) s_bvalid <= 1'b0;
      if (wr_fire) begin
        aw_hold   <= 1'b0;
        w_hold    <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
        s_bvalid  <= 1'b1;
        s_bresp   <= mapped(aw_q) ? `UDC_RESP_OKAY : `UDC_RESP_SLVERR;
      end else begin
        if (aw_take) aw_q <= s_awaddr;
        if (w_take) begin
          wd_q <= s_wdata;
          ws_q <= s_wstrb;
        end
        aw_hold   <= aw_hold | aw_take;
        w_hold    <= w_hold | w_take;
        s_awready <= ~(aw_hold | aw_take);
        s_wready  <= ~(w_hold | w_take);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= `UDC_RST_WORD;
      s_rresp   <= `UDC_RESP_OKAY;
    end else if (s_rvalid) begin
      if (s_rready) begin
        s_rvalid  <= 1'b0;
        s_arready <= 1'b1;
      end
    end else if (ar_take) begin
      s_rvalid  <= 1'b1;
      s_arready <= 1'b0;
      s_rresp   <= mapped(s_araddr) ? `UDC_RESP_OKAY : `UDC_RESP_SLVERR;
      case (s_araddr)
        `UDC_REG_ENA_SET, `UDC_REG_ENA_CLR: s_rdata <= en;
        `UDC_REG_PRI_SET, `UDC_REG_PRI_CLR: s_rdata <= prio;
        `UDC_REG_BO_SET, `UDC_REG_BO_CLR:   s_rdata <= bonly;
        `UDC_REG_BASE: s_rdata <= tbl_base;
        `UDC_REG_ALT:  s_rdata <= alt_sel;
        `UDC_REG_STAT: s_rdata <= {26'h000_0000, dma_busy, ch};
        default:       s_rdata <= `UDC_RST_WORD;
      endcase
    end else begin
      s_arready <= 1'b1;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_PRIO_HIGH: assert property (arb_bus.gnt_valid && |(eligible & prio)
    |-> prio[arb_bus.gnt_idx]) else $error("high level channel skipped");
  AST_PRIO_LOWEST: assert property (arb_bus.gnt_valid
    |-> (eligible & ((32'h0000_0001 << arb_bus.gnt_idx) - 32'h0000_0001)
        & (prio[arb_bus.gnt_idx] ? prio : ~prio)) == '0)
    else $error("lower numbered channel skipped");
  AST_PRIO_SET: assert property (wr_fire && aw_q == `UDC_REG_PRI_SET
    |=> (prio & $past(pri_s)) == $past(pri_s)) else $error("priority set lost");
  AST_PRIO_CLR: assert property (wr_fire && aw_q == `UDC_REG_PRI_CLR
    |=> (prio & $past(pri_c)) == '0) else $error("priority clear lost");
  AST_GNT_ENABLED: assert property (state == ST_IDLE && arb_bus.gnt_valid
    |-> en[arb_bus.gnt_idx]) else $error("disabled channel granted");
  AST_BURST_ONLY: assert property (state == ST_IDLE && arb_bus.gnt_valid
    |-> breq_s[arb_bus.gnt_idx] || auto_run[arb_bus.gnt_idx]
        || !bonly[arb_bus.gnt_idx]) else $error("single served on burst-only");
  AST_CPU_YIELD: assert property (cpu_bus_busy |=> !mem_req)
    else $error("master did not yield");
  AST_STOP_OFF: assert property (stop_hit && !(|ena_s)
    |=> state == ST_IDLE && !en[ch]) else $error("stop mode left channel on");
  AST_BURST_LEN: assert property ((state == ST_CW) && mem_done && is_burst
    |=> left == (($past(rd_arbn) < $past(rd_cnt)) ? $past(rd_arbn) : $past(rd_cnt)))
    else $error("burst length wrong");
  AST_SINGLE_ONE: assert property ((state == ST_WR) && mem_done && left == 11'd1
    |=> state == ST_WB) else $error("single moved more than one item");
  AST_WB_STOP: assert property ((state == ST_WB) && mem_req && rem == 11'd0
    |-> mem_wdata[1:0] == `UDC_MODE_STOP && mem_wdata[`UDC_CW_CNT] == 11'd0)
    else $error("final write back not stop");

  COV_BURST: cover property ((state == ST_WR) && mem_done ##1 state == ST_RD);
  COV_PP: cover property (xfer_end && cw[`UDC_CW_MODE] == `UDC_MODE_PP);
  COV_STALL: cover property (mem_req ##1 cpu_bus_busy ##1 !mem_req);
endmodule : udc_top

// File: verif/tb_top.sv
// self-checking bench for the dma channel engine
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // signals and instances
  logic        clk, rst_b, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, cpu_bus_busy, mem_req, mem_we;
  logic        mem_ack, dma_busy;
  logic [7:0]  s_awaddr, s_araddr;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, mem_size, rsp;
  logic [31:0] s_wdata, s_rdata, dma_sreq, dma_breq, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] chan_done, rd;
  int          errors, samples_checked, first, prio;

  udc_top dut (.clk(clk), .rst_b(rst_b), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .dma_sreq(dma_sreq),
    .dma_breq(dma_breq), .cpu_bus_busy(cpu_bus_busy), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .chan_done(chan_done), .dma_busy(dma_busy));
  udc_mem_model far (.clk(clk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cpu_bus_busy(cpu_bus_busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================
  // shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task axi(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, done;
    done = 1'b0;
    @(posedge clk);
    if (we) begin
      s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
    end else begin
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    end
    for (int n = 0; n < 60 && !done; n++) begin
      @(negedge clk);
      ta = s_awvalid && s_awready; tw = s_wvalid && s_wready; tr = s_arvalid && s_arready;
      done = (s_bvalid && s_bready) || (s_rvalid && s_rready);
      rsp = we ? s_bresp : s_rresp;
      rd = s_rdata;
      @(posedge clk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      if (tr) s_arvalid <= 1'b0;
      if (done) begin
        s_bready <= 1'b0; s_rready <= 1'b0;
      end
    end
    if (!done) begin
      errors++;
      finish_test();
    end
  endtask : axi

  task wait_done(input int c);
    for (int n = 0; chan_done[c] !== 1'b1; n++) begin
      @(negedge clk);
      if (n > 4000) begin
        errors++;
        finish_test();
      end
    end
    @(posedge clk);
  endtask : wait_done

  function automatic logic [31:0] cw(input int a, input int n, input int m);
    return {8'hAA, a[9:0], n[10:0], 1'b0, m[1:0]};
  endfunction : cw

  // table entry, word buffers and enable for channel c
  task setup(input int c, input int n, input int a, input int m);
    int b;
    b = (32'h0000_0400 + 16 * c) / 4;
    for (int i = 0; i < n; i++) begin
      far.mem[(32'h0000_0800 + 32 * c) / 4 + i] = $urandom;
      far.mem[(32'h0000_0C00 + 32 * c) / 4 + i] = 32'h0000_0000;
    end
    far.mem[b] = 32'h0000_0800 + 32 * c + 4 * (n - 1);
    far.mem[b + 1] = 32'h0000_0C00 + 32 * c + 4 * (n - 1);
    far.mem[b + 2] = cw(a, n, m);
    axi(1'b1, 8'h00, 32'h0000_0001 << c);
  endtask : setup

  function automatic int pick(input int req, input int pr);
    for (int i = 0; i < 32; i++) if (req[i] && pr[i]) return i;
    for (int i = 0; i < 32; i++) if (req[i]) return i;
    return -1;
  endfunction : pick

  // ==========================================
  // main sequence
  initial begin
    errors = 0; samples_checked = 0; prio = 0;
    void'($urandom(4273));
    rst_b = 1'b0; s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0; s_arvalid = 1'b0;
    s_rready = 1'b0; s_awaddr = 8'h00; s_araddr = 8'h00; s_wdata = 32'h0000_0000;
    s_wstrb = 4'hF; dma_sreq = 32'h0000_0000; dma_breq = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    axi(1'b1, 8'h18, 32'h0000_0400);
    check({30'h0000_0000, rsp}, 32'h0000_0000);
    axi(1'b0, 8'h18, 32'h0000_0000);
    check(rd, 32'h0000_0400);
    axi(1'b0, 8'h28, 32'h0000_0000);
    check({30'h0000_0000, rsp}, 32'h0000_0002);
    $display("test registers done");
    setup(3, 4, 1, 1);
    dma_breq[3] <= 1'b1;
    wait_done(3);
    dma_breq[3] <= 1'b0;
    check(far.cw_log.size(), 2);
    for (int i = 0; i < 4; i++) check(far.mem[(32'h0000_0C60) / 4 + i], far.mem[32'h0000_0860 / 4 + i]);
    check(far.mem[32'h0000_0430 / 4 + 2], cw(1, 0, 0));
    check(far.mem[32'h0000_0430 / 4], 32'h0000_086C);
    axi(1'b0, 8'h00, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test burst done");
    for (int p = 0; p < 3; p++) begin
      far.cw_log.delete();
      setup(5, 1, 0, 1);
      setup(6, 1, 0, 1);
      axi(1'b1, (p == 2) ? 8'h0C : 8'h08, (p == 0) ? 32'h0000_0040 : 32'h0000_0060);
      prio = (p == 2) ? 0 : ((p == 0) ? 32'h0000_0040 : 32'h0000_0060);
      first = pick(32'h0000_0060, prio);
      dma_breq <= 32'h0000_0060;
      wait_done(first);
      wait_done(11 - first);
      dma_breq <= 32'h0000_0000;
      check(far.cw_log[0], first);
    end
    axi(1'b0, 8'h0C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("test priority done");
    far.cw_log.delete();
    axi(1'b1, 8'h10, 32'h0000_0080);
    setup(7, 1, 0, 1);
    dma_sreq[7] <= 1'b1;
    repeat (40) @(posedge clk);
    check(far.cw_log.size(), 0);
    dma_breq[7] <= 1'b1;
    wait_done(7);
    dma_breq <= 32'h0000_0000;
    dma_sreq <= 32'h0000_0000;
    check(far.mem[32'h0000_0CE0 / 4], far.mem[32'h0000_08E0 / 4]);
    $display("test burst only done");
    setup(9, 1, 0, 0);
    dma_breq[9] <= 1'b1;
    repeat (40) @(posedge clk);
    dma_breq <= 32'h0000_0000;
    axi(1'b0, 8'h00, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(far.mem[32'h0000_0D20 / 4], 32'h0000_0000);
    axi(1'b0, 8'h20, 32'h0000_0000);
    check(rd, 32'h0000_0009);
    $display("test stop mode done");
    finish_test();
  end
endmodule : tb_top

// File: verif/udc_mem_model.sv
// system memory and processor bus activity seen by the dma master
`timescale 1ns/1ps
module udc_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic             cpu_bus_busy
);
  // ==========================================
  // memory with slow and prompt answers
  logic [31:0] mem [1024];
  logic        go;
  int          cw_log[$];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      go           <= 1'b0;
      cpu_bus_busy <= 1'b0;
    end else begin
      go           <= ($urandom % 3) != 0;
      cpu_bus_busy <= ($urandom % 5) == 0;
    end
  end

  assign mem_ack = mem_req & go & ~cpu_bus_busy;
  // stale data shown inverted off the ack cycle
  assign mem_rdata = mem_ack ? mem[mem_addr[11:2]] : ~mem[mem_addr[11:2]];

  // primary control word fetches logged by channel
  always @(posedge clk) begin
    if (mem_req && mem_ack && mem_we) mem[mem_addr[11:2]] <= mem_wdata;
    if (mem_req && mem_ack && !mem_we && mem_addr[3:0] == 4'h8 && mem_addr[11:9] == 3'h2)
      cw_log.push_back(int'(mem_addr[8:4]));
  end
endmodule : udc_mem_model
